// >>> design/option_cfg_pkg.sv
// Purpose: Constants and types shared by the option byte decoder
// Assumes: Option bytes are 8 bits wide, two of them
// Notes: Bit positions and codes follow the option byte layout
package option_cfg_pkg;

  // ------------------------------------------------------------
  // Storage layout
  // ------------------------------------------------------------
  localparam logic [7:0] BLANK_BYTE = 8'h00_FF;
  localparam int OB0_RESET_ON_HALT = 7;
  localparam int OB0_WDOG_SOFT = 6;
  localparam int OB0_PROTECT_N = 0;
  localparam int OB1_PACKAGE = 7;
  localparam int OB1_RESET_CYC = 6;
  localparam int OB1_SRC_HI = 5;
  localparam int OB1_SRC_LO = 4;
  localparam int OB1_RANGE_HI = 3;
  localparam int OB1_RANGE_LO = 1;
  localparam int OB1_PLL_OFF = 0;

  // ------------------------------------------------------------
  // Field codes and counts
  // ------------------------------------------------------------
  localparam logic [1:0] SRC_RESONATOR = 2'h0_0;
  localparam logic [1:0] SRC_RESERVED = 2'h0_1;
  localparam logic [1:0] SRC_INTERNAL_RC = 2'h0_2;
  localparam logic [1:0] SRC_EXTERNAL = 2'h0_3;
  localparam logic [2:0] RANGE_LOW_POWER = 3'h0_0;
  localparam logic [2:0] RANGE_MEDIUM_POWER = 3'h0_1;
  localparam logic [2:0] RANGE_MEDIUM_SPEED = 3'h0_2;
  localparam logic [2:0] RANGE_HIGH_SPEED = 3'h0_3;
  localparam logic [12:0] RESET_CYCLES_LONG = 13'h1_000;
  localparam logic [12:0] RESET_CYCLES_SHORT = 13'h0_100;
  localparam logic [7:0] ROM_BYTE_ZERO = 8'h00_FF;
  localparam logic [7:0] ROM_BYTE_ONE = 8'h00_E7;

  // ------------------------------------------------------------
  // Decoded configuration
  // ------------------------------------------------------------
  typedef struct packed {
    logic wdog_reset_on_halt;
    logic wdog_soft_select;
    logic readout_protect;
    logic package_select;
    logic [12:0] reset_cycles;
    logic [1:0] clock_source_type;
    logic [2:0] resonator_range;
    logic pll_enable;
  } option_cfg_t;

  typedef enum logic [1:0] {ST_IDLE, ST_MEM_ERASE, ST_OPT_ERASE} erase_state_t;

endpackage

// >>> design/option_byte_config_decoder.sv
// Purpose: Option byte storage, programming access and static configuration decode
// Assumes: Programming port is only driven by the programming tool
// Notes: Storage survives rst_b; por_b and the option erase state blank it

`timescale 1ns/1ns

module option_byte_config_decoder #(
  parameter bit MASK_ROM = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic por_b,
  input wire logic prog_mode,
  input wire logic prog_sel,
  input wire logic prog_wr,
  input wire logic [7:0] prog_wdata,
  input wire logic prog_erase,
  output logic [7:0] prog_rdata,
  output logic erase_busy,
  output logic user_erase_req,
  input wire logic user_erase_done,
  input wire logic flash_wr_req,
  output logic flash_wr_ok,
  input wire logic dump_req,
  output logic dump_ok,
  output option_cfg_pkg::option_cfg_t cfg,
  output logic unbonded_pullup
);

  // ------------------------------------------------------------
  // Storage and programming access
  // ------------------------------------------------------------
  logic [7:0] byte_zero_ff;
  logic [7:0] byte_one_ff;
  logic [7:0] prog_rdata_ff;
  option_cfg_pkg::option_cfg_t cfg_ff;
  option_cfg_pkg::erase_state_t state_ff;
  option_cfg_pkg::erase_state_t nxt_state;

  wire prog_ok = prog_mode && !MASK_ROM;
  wire wr_take = prog_ok && prog_wr && (state_ff == option_cfg_pkg::ST_IDLE);
  wire opt_blank = !por_b || (state_ff == option_cfg_pkg::ST_OPT_ERASE);
  wire [7:0] sel_byte = prog_sel ? byte_one_ff : byte_zero_ff;
  wire [7:0] nxt_prog_rdata = prog_ok ? sel_byte : 8'h00_00;

  always_ff @(posedge clk) begin
    if (opt_blank) begin
      byte_zero_ff <= option_cfg_pkg::BLANK_BYTE;
      byte_one_ff <= option_cfg_pkg::BLANK_BYTE;
    end else if (wr_take) begin
      if (prog_sel) begin
        byte_one_ff <= prog_wdata;
      end else begin
        byte_zero_ff <= prog_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prog_rdata_ff <= 8'h00_00;
    end else begin
      prog_rdata_ff <= nxt_prog_rdata;
    end
  end

  assign prog_rdata = prog_rdata_ff;

  // ------------------------------------------------------------
  // Option erase sequence
  // ------------------------------------------------------------
  // A protected part must lose its user code before the protection bit can be cleared; a programming write to byte zero is not blocked and can clear it
  wire protected_now = !byte_zero_ff[option_cfg_pkg::OB0_PROTECT_N];
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      option_cfg_pkg::ST_IDLE: begin
        if (prog_ok && prog_erase) begin
          nxt_state = protected_now ? option_cfg_pkg::ST_MEM_ERASE : option_cfg_pkg::ST_OPT_ERASE;
        end
      end
      option_cfg_pkg::ST_MEM_ERASE: begin
        if (user_erase_done) begin
          nxt_state = option_cfg_pkg::ST_OPT_ERASE;
        end
      end
      option_cfg_pkg::ST_OPT_ERASE: begin
        nxt_state = option_cfg_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = option_cfg_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= option_cfg_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign user_erase_req = (state_ff == option_cfg_pkg::ST_MEM_ERASE);
  assign erase_busy = (state_ff != option_cfg_pkg::ST_IDLE);

  // ------------------------------------------------------------
  // Decode, captured only while reset is held
  // ------------------------------------------------------------
  wire [7:0] src_zero = MASK_ROM ? option_cfg_pkg::ROM_BYTE_ZERO : byte_zero_ff;
  wire [7:0] src_one = MASK_ROM ? option_cfg_pkg::ROM_BYTE_ONE : byte_one_ff;
  // A net, so that each field may have its own continuous assignment
  wire option_cfg_pkg::option_cfg_t nxt_cfg;
  assign nxt_cfg.wdog_reset_on_halt = src_zero[option_cfg_pkg::OB0_RESET_ON_HALT];
  assign nxt_cfg.wdog_soft_select = src_zero[option_cfg_pkg::OB0_WDOG_SOFT];
  assign nxt_cfg.readout_protect = !src_zero[option_cfg_pkg::OB0_PROTECT_N];
  assign nxt_cfg.package_select = src_one[option_cfg_pkg::OB1_PACKAGE];
  assign nxt_cfg.reset_cycles = src_one[option_cfg_pkg::OB1_RESET_CYC] ?
    option_cfg_pkg::RESET_CYCLES_SHORT : option_cfg_pkg::RESET_CYCLES_LONG;
  assign nxt_cfg.clock_source_type = src_one[option_cfg_pkg::OB1_SRC_HI:option_cfg_pkg::OB1_SRC_LO];
  assign nxt_cfg.resonator_range = src_one[option_cfg_pkg::OB1_RANGE_HI:option_cfg_pkg::OB1_RANGE_LO];
  assign nxt_cfg.pll_enable = !src_one[option_cfg_pkg::OB1_PLL_OFF];

  // Programming after reset release takes effect only at the next reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_ff <= nxt_cfg;
    end
  end

  assign cfg = cfg_ff;

  // ------------------------------------------------------------
  // Protection gates and pad bonding
  // ------------------------------------------------------------
  assign flash_wr_ok = flash_wr_req && !cfg_ff.readout_protect;
  assign dump_ok = dump_req && !cfg_ff.readout_protect;
  // 32-pin bonding leaves pads of every 8-pad port unbonded; they must stay pulled up
  assign unbonded_pullup = !cfg_ff.package_select;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Storage is unknown until the first power-on clear, so decoded-value checks other than a_cfg_held_stable, a_protect_blocks and a_src_decode wait for it
  a_cfg_held_stable: assert property (@(posedge clk) rst_b && $past(rst_b) |-> $stable(cfg_ff))
    else $error("configuration changed outside reset");

  a_cfg_sampled_reset: assert property (@(posedge clk) disable iff (!por_b)
    !rst_b && !MASK_ROM |=> cfg_ff.pll_enable == !$past(byte_one_ff[option_cfg_pkg::OB1_PLL_OFF]))
    else $error("pll enable not sampled from storage");

  a_blank_after_por: assert property (@(posedge clk) !por_b |=>
    byte_zero_ff == option_cfg_pkg::BLANK_BYTE && byte_one_ff == option_cfg_pkg::BLANK_BYTE)
    else $error("storage not blank after power on");

  a_read_needs_mode: assert property (@(posedge clk) disable iff (!rst_b) !prog_mode |=> prog_rdata == 8'h00_00)
    else $error("option bytes readable outside programming mode");

  a_rdata_follows_sel: assert property (@(posedge clk) disable iff (!rst_b)
    prog_ok |=> prog_rdata == $past(sel_byte))
    else $error("read data does not follow the selected byte");

  a_write_needs_mode: assert property (@(posedge clk) disable iff (!por_b)
    !prog_mode && state_ff == option_cfg_pkg::ST_IDLE |=> $stable(byte_zero_ff) && $stable(byte_one_ff))
    else $error("option bytes written outside programming mode");

  a_rom_port_dead: assert property (@(posedge clk) disable iff (!rst_b)
    MASK_ROM |=> prog_rdata == 8'h00_00 && !erase_busy && !user_erase_req)
    else $error("factory coded part answered the programming port");

  a_protect_blocks: assert property (@(posedge clk) cfg_ff.readout_protect |-> !flash_wr_ok && !dump_ok)
    else $error("protected part allowed access");

  a_open_grants: assert property (@(posedge clk) disable iff (!por_b)
    !cfg_ff.readout_protect |-> flash_wr_ok == flash_wr_req && dump_ok == dump_req)
    else $error("unprotected part refused access");

  a_erase_order: assert property (@(posedge clk) disable iff (!rst_b)
    state_ff == option_cfg_pkg::ST_IDLE && prog_ok && prog_erase && protected_now
    |=> user_erase_req && byte_zero_ff[0] == 1'b0)
    else $error("options erased before user memory");

  a_user_erase_held: assert property (@(posedge clk) disable iff (!rst_b)
    user_erase_req && !user_erase_done |=> user_erase_req)
    else $error("user erase request dropped before completion");

  a_erase_finish: assert property (@(posedge clk) disable iff (!rst_b)
    user_erase_req && user_erase_done |=> state_ff == option_cfg_pkg::ST_OPT_ERASE ##1
    (byte_zero_ff == 8'h00_FF && !erase_busy))
    else $error("option erase did not follow user erase");

  a_open_erase: assert property (@(posedge clk) disable iff (!rst_b)
    state_ff == option_cfg_pkg::ST_IDLE && prog_ok && prog_erase && !protected_now
    |=> state_ff == option_cfg_pkg::ST_OPT_ERASE ##1
    (byte_zero_ff == option_cfg_pkg::BLANK_BYTE && byte_one_ff == option_cfg_pkg::BLANK_BYTE && !erase_busy))
    else $error("unprotected option erase did not blank storage");

  a_reset_count: assert property (@(posedge clk) disable iff (!por_b)
    (cfg_ff.reset_cycles == option_cfg_pkg::RESET_CYCLES_SHORT ||
    cfg_ff.reset_cycles == option_cfg_pkg::RESET_CYCLES_LONG) and
    (rst_b && $past(!rst_b) && !MASK_ROM |-> (cfg_ff.reset_cycles == option_cfg_pkg::RESET_CYCLES_SHORT) ==
    $past(byte_one_ff[option_cfg_pkg::OB1_RESET_CYC])))
    else $error("reset cycle count wrong");

  a_src_decode: assert property (@(posedge clk) rst_b && $past(!rst_b) && !MASK_ROM |->
    cfg_ff.clock_source_type == $past(byte_one_ff[5:4]) && cfg_ff.resonator_range == $past(byte_one_ff[3:1]))
    else $error("clock source fields decoded wrongly");

  a_pkg_pads: assert property (@(posedge clk) disable iff (!por_b)
    unbonded_pullup != cfg_ff.package_select)
    else $error("pad pull-up state disagrees with package");

endmodule

// >>> bench/prog_tool_model.sv
// Purpose: Programming tool model that drives the option programming port
// Assumes: Requests change on the falling clock edge and are held across one rising edge
// Notes: Values handed in are made legal the way a careful tool would before writing
`timescale 1ns/1ns
module prog_tool_model (
  input wire logic clk,
  input wire logic [7:0] prog_rdata,
  output logic prog_mode,
  output logic prog_sel,
  output logic prog_wr,
  output logic [7:0] prog_wdata,
  output logic prog_erase
);
  initial begin
    prog_mode = 1'b0;
    prog_sel = 1'b0;
    prog_wr = 1'b0;
    prog_wdata = 8'h00_00;
    prog_erase = 1'b0;
  end
  task automatic set_mode(input logic m);
    @(negedge clk);
    prog_mode = m;
  endtask
  task automatic write_byte(input logic sel, input logic [7:0] data);
    logic [7:0] legal;
    legal = data;
    if (!sel) legal[5:1] = 5'h0_0;
    if (sel && legal[5:4] == option_cfg_pkg::SRC_EXTERNAL) legal[3:1] = option_cfg_pkg::RANGE_MEDIUM_POWER;
    if (sel && (legal[5:4] == option_cfg_pkg::SRC_INTERNAL_RC || legal[3:1] != option_cfg_pkg::RANGE_MEDIUM_POWER))
      legal[0] = 1'b1;
    @(negedge clk);
    prog_sel = sel;
    prog_wdata = legal;
    prog_wr = 1'b1;
    @(negedge clk);
    prog_wr = 1'b0;
    // Released data must not look like the last byte written
    prog_wdata = ~legal;
  endtask
  task automatic read_byte(input logic sel, output logic [7:0] data);
    @(negedge clk);
    prog_sel = sel;
    repeat (2) @(negedge clk);
    data = prog_rdata;
  endtask
  task automatic erase_opt();
    @(negedge clk);
    prog_erase = 1'b1;
    @(negedge clk);
    prog_erase = 1'b0;
  endtask
endmodule

// >>> bench/option_byte_config_decoder_tb_top.sv
// Purpose: Self-checking bench for the option byte decoder
// Assumes: Tool model drives the programming port, the bench drives the rest
// Notes: A second instance is built as a mask-programmed part
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module option_byte_config_decoder_tb_top;
  logic clk, rst_b, por_b, user_erase_done, flash_wr_req, dump_req;
  logic prog_mode, prog_sel, prog_wr, prog_erase, erase_busy, user_erase_req, flash_wr_ok, dump_ok, unbonded_pullup;
  logic [7:0] prog_wdata, prog_rdata, rom_rdata, rd;
  option_cfg_pkg::option_cfg_t cfg, rom_cfg;
  int failures = 0;
  int checks_done = 0;
  logic [7:0] b0_tab [6] = '{8'h00_C1, 8'h00_01, 8'h00_81, 8'h00_41, 8'h00_C1, 8'h00_01};
  logic [7:0] b1_tab [6] = '{8'h00_02, 8'h00_23, 8'h00_73, 8'h00_C7, 8'h00_91, 8'h00_45};
  option_byte_config_decoder i_dut (.clk, .rst_b, .por_b, .prog_mode, .prog_sel, .prog_wr, .prog_wdata,
    .prog_erase, .prog_rdata, .erase_busy, .user_erase_req, .user_erase_done, .flash_wr_req, .flash_wr_ok,
    .dump_req, .dump_ok, .cfg, .unbonded_pullup);
  option_byte_config_decoder #(.MASK_ROM(1'b1)) i_rom (.clk, .rst_b, .por_b, .prog_mode, .prog_sel, .prog_wr,
    .prog_wdata, .prog_erase, .prog_rdata(rom_rdata), .erase_busy(), .user_erase_req(), .user_erase_done,
    .flash_wr_req, .flash_wr_ok(), .dump_req, .dump_ok(), .cfg(rom_cfg), .unbonded_pullup());
  prog_tool_model i_tool (.clk, .prog_rdata, .prog_mode, .prog_sel, .prog_wr, .prog_wdata, .prog_erase);
  function automatic option_cfg_pkg::option_cfg_t exp_cfg(input logic [7:0] b0, input logic [7:0] b1);
    exp_cfg = {b0[7], b0[6], ~b0[0], b1[7], b1[6] ? 13'h0_100 : 13'h1_000, b1[5:4], b1[3:1], ~b1[0]};
  endfunction
  task automatic do_reset();
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 20 && erase_busy !== 1'b0; k++) @(negedge clk);
    `CHK("idle", 1'b0, erase_busy)
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A hang costs far more than the roughly 120 cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    por_b = 1'b0;
    user_erase_done = 1'b0;
    flash_wr_req = 1'b1;
    dump_req = 1'b1;
    repeat (8) @(negedge clk);
    por_b = 1'b1;
    rst_b = 1'b1;
    `CHK("cfg blank", exp_cfg(8'h00_FF, 8'h00_FF), cfg)
    `CHK("rom cfg", exp_cfg(option_cfg_pkg::ROM_BYTE_ZERO, option_cfg_pkg::ROM_BYTE_ONE), rom_cfg)
    i_tool.read_byte(1'b0, rd);
    `CHK("rdata off", 8'h00_00, rd)
    i_tool.write_byte(1'b0, 8'h00_40);
    i_tool.set_mode(1'b1);
    i_tool.read_byte(1'b0, rd);
    `CHK("blank zero", 8'h00_FF, rd)
    i_tool.read_byte(1'b1, rd);
    `CHK("blank one", 8'h00_FF, rd)
    for (int i = 0; i < 6; i++) begin
      i_tool.write_byte(1'b0, b0_tab[i]);
      i_tool.write_byte(1'b1, b1_tab[i]);
      do_reset();
      `CHK("cfg", exp_cfg(b0_tab[i], b1_tab[i]), cfg)
      `CHK("pullup", ~b1_tab[i][7], unbonded_pullup)
      `CHK("wr ok", 1'b1, flash_wr_ok)
      i_tool.write_byte(1'b1, ~b1_tab[i]);
      repeat (3) @(negedge clk);
      `CHK("cfg held", exp_cfg(b0_tab[i], b1_tab[i]), cfg)
    end
    `CHK("rom rdata", 8'h00_00, rom_rdata)
    i_tool.erase_opt();
    `CHK("busy", 1'b1, erase_busy)
    wait_idle();
    i_tool.read_byte(1'b1, rd);
    `CHK("erased", 8'h00_FF, rd)
    i_tool.write_byte(1'b0, 8'h00_FE);
    do_reset();
    `CHK("protect", 1'b1, cfg.readout_protect)
    `CHK("wr blocked", 1'b0, flash_wr_ok)
    `CHK("dump blocked", 1'b0, dump_ok)
    i_tool.erase_opt();
    repeat (4) @(negedge clk);
    `CHK("user erase", 1'b1, user_erase_req)
    i_tool.read_byte(1'b0, rd);
    `CHK("not yet", 8'h00_C0, rd)
    user_erase_done = 1'b1;
    @(negedge clk);
    user_erase_done = 1'b0;
    wait_idle();
    i_tool.read_byte(1'b0, rd);
    `CHK("erased zero", 8'h00_FF, rd)
    do_reset();
    `CHK("unprotected", 1'b1, flash_wr_ok)
    `CHK("dump ok", 1'b1, dump_ok)
    flash_wr_req = 1'b0;
    dump_req = 1'b0;
    @(negedge clk);
    `CHK("wr idle", 1'b0, flash_wr_ok)
    `CHK("dump idle", 1'b0, dump_ok)
    test_done();
  end
endmodule
